// ==== flash_dev_end.sv ====
// What this block does
// - Block erase dropped unless select rises on boundary
// - Select rise starts timed block erase
// - Busy flag high during every erase cycle
// - Write permit cleared before erase completes
// - Erase of protected block is not done
// - Top four address bits are ignored
// - Array erase leaves every block all ones
// - Array erase needs write permit latch set
// - Array erase needs select rise after opcode
// - Select rise starts timed array erase, busy
// - Array erase only with protect bits zero
// - Deselect gives standby, only sleep command sleeps
// - Deep sleep ignores all but wake command
// - Sleep needs exact opcode, enters after delay
// - Sleep command rejected during busy cycle
// - Reset always comes up in standby
// - Ident read shifts out maker, type, capacity
// - Ident read ignored during erase
// - Select rise ends reads, returns to standby
// - Pair read takes opcode, two dummies, address
// - Address one swaps device and maker order
// - Pair read ignored during erase
`timescale 1ns/10ps
`default_nettype none
module flash_dev_end
  import flash_link_pkg::*;
#(
  parameter int unsigned BLOCK_ERASE_CYCLES = flash_link_pkg::BLOCK_ERASE_CYC,
  parameter int unsigned ARRAY_ERASE_CYCLES = flash_link_pkg::ARRAY_ERASE_CYC,
  parameter int unsigned SLEEP_CYCLES       = flash_link_pkg::SLEEP_ENTRY_CYC
)
(
  input  wire logic                  clk_in,
  input  wire logic                  reset_in,
  spi_link_if.device                 link,
  input  wire logic [NUM_BLOCKS-1:0] dirty_blocks_in,
  input  wire logic [2:0]            protect_level_bits_in,
  output logic                       write_busy_flag_out,
  output logic                       write_permit_latch_out,
  output logic                       deep_sleep_out,
  output logic [NUM_BLOCKS-1:0]      blank_blocks_out
);
  import flash_link_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detect
  // ----------------------------------------------------------------
  logic [2:0]  sel_q;
  logic [2:0]  sclk_q;
  logic [1:0]  mosi_q;
  logic        sel_rise;
  logic        sel_low;
  logic        clk_rise;
  logic        clk_fall;

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      sel_q  <= 3'h7;
      sclk_q <= 3'h0;
      mosi_q <= 2'h0;
    end
    else
    begin
      sel_q  <= {sel_q[1:0], link.sel_n};
      sclk_q <= {sclk_q[1:0], link.sclk};
      mosi_q <= {mosi_q[0], link.serial_in_line};
    end
  end

  assign sel_low  = ~sel_q[1];
  assign sel_rise = sel_q[1] & ~sel_q[2];
  assign clk_rise = sel_low & sclk_q[1] & ~sclk_q[2];
  assign clk_fall = sel_low & ~sclk_q[1] & sclk_q[2];

  // ----------------------------------------------------------------
  // Input shifter and bit count
  // ----------------------------------------------------------------
  logic [31:0] sr_q;
  logic [31:0] sr_d;
  logic [5:0]  cnt_q;
  logic [7:0]  cmd_q;

  assign sr_d = {sr_q[30:0], mosi_q[1]};

  always_ff @(posedge clk_in)
  begin
    if (reset_in || !sel_low)
    begin
      sr_q  <= 32'h0;
      cnt_q <= 6'h0;
      cmd_q <= 8'h0;
    end
    else if (clk_rise)
    begin
      sr_q <= sr_d;
      if (cnt_q != 6'h3F)
        cnt_q <= cnt_q + 6'h1;
      if (cnt_q == OPCODE_BITS - 6'h1)
        cmd_q <= sr_d[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Command acceptance on select rise
  // ----------------------------------------------------------------
  logic                       busy_q;
  logic                       permit_q;
  logic                       sleep_q;
  logic                       sleep_pend_q;
  logic                       awake;
  logic [BLOCK_W-1:0]         blk;
  logic                       blk_prot;
  logic                       be_ok;
  logic                       ce_ok;
  logic                       dp_ok;
  logic                       unlock_ok;
  logic                       wake_ok;

  assign awake = !sleep_q && !sleep_pend_q;
  assign blk   = sr_q[BLOCK_LSB +: BLOCK_W];

  // Level n protects the top 2^(n-1) blocks; level 5 and above covers all
  always_comb
  begin
    if (protect_level_bits_in == 3'h0)
      blk_prot = 1'b0;
    else if (protect_level_bits_in >= 3'h5)
      blk_prot = 1'b1;
    else
      blk_prot = ({1'b0, blk} >= 5'(NUM_BLOCKS - (1 << (protect_level_bits_in - 3'h1))));
  end

  assign be_ok = sel_rise && cmd_q == OP_BLOCK_ERASE && cnt_q == FULL_BITS
               && permit_q && !busy_q && awake && !blk_prot;
  assign ce_ok = sel_rise && cmd_q == OP_ARRAY_ERASE && cnt_q == OPCODE_BITS
               && permit_q && !busy_q && awake
               && protect_level_bits_in == 3'h0;
  assign dp_ok = sel_rise && cmd_q == OP_DEEP_SLEEP && cnt_q == OPCODE_BITS
               && !busy_q && awake;
  assign unlock_ok = sel_rise && cmd_q == OP_WRITE_UNLOCK && cnt_q == OPCODE_BITS
                   && !busy_q && awake;
  assign wake_ok = sel_rise && cmd_q == OP_WAKE_SIG && cnt_q >= OPCODE_BITS && !busy_q;

  // ----------------------------------------------------------------
  // Self-timed erase
  // ----------------------------------------------------------------
  logic [31:0]           erase_cnt_q;
  logic [NUM_BLOCKS-1:0] target_q;
  logic [NUM_BLOCKS-1:0] done_mask;
  logic [NUM_BLOCKS-1:0] blank_q;

  assign done_mask = (busy_q && erase_cnt_q == 32'h1) ? target_q : '0;

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      busy_q      <= 1'b0;
      erase_cnt_q <= 32'h0;
      target_q    <= '0;
    end
    else if (be_ok)
    begin
      busy_q      <= 1'b1;
      erase_cnt_q <= 32'(BLOCK_ERASE_CYCLES);
      target_q    <= NUM_BLOCKS'(1) << blk;
    end
    else if (ce_ok)
    begin
      busy_q      <= 1'b1;
      erase_cnt_q <= 32'(ARRAY_ERASE_CYCLES);
      target_q    <= '1;
    end
    else if (busy_q)
    begin
      erase_cnt_q <= erase_cnt_q - 32'h1;
      if (erase_cnt_q == 32'h1)
        busy_q <= 1'b0;
    end
  end

  // A block written elsewhere is no longer blank; an erase finishing wins
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      blank_q <= '1;
    else
      blank_q <= (blank_q & ~dirty_blocks_in) | done_mask;
  end

  // Cleared at erase start, well before completion
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      permit_q <= 1'b0;
    else if (be_ok || ce_ok)
      permit_q <= 1'b0;
    else if (unlock_ok)
      permit_q <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Deep sleep
  // ----------------------------------------------------------------
  logic [31:0] sleep_cnt_q;

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      sleep_q      <= 1'b0;
      sleep_pend_q <= 1'b0;
      sleep_cnt_q  <= 32'h0;
    end
    else if (wake_ok)
    begin
      sleep_q      <= 1'b0;
      sleep_pend_q <= 1'b0;
    end
    else if (dp_ok)
    begin
      sleep_pend_q <= 1'b1;
      sleep_cnt_q  <= 32'(SLEEP_CYCLES);
    end
    else if (sleep_pend_q)
    begin
      sleep_cnt_q <= sleep_cnt_q - 32'h1;
      if (sleep_cnt_q == 32'h1)
      begin
        sleep_pend_q <= 1'b0;
        sleep_q      <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Data-out phase
  // ----------------------------------------------------------------
  logic [23:0] out_sr_q;
  logic        out_act_q;
  logic        miso_q;
  logic        oe_n_q;

  always_ff @(posedge clk_in)
  begin
    if (reset_in || !sel_low)
    begin
      out_act_q <= 1'b0;
      out_sr_q  <= 24'h0;
    end
    else if (clk_rise && !busy_q)
    begin
      if (cnt_q == OPCODE_BITS - 6'h1 && sr_d[7:0] == OP_IDENT_TRIPLET && awake)
      begin
        out_act_q <= 1'b1;
        out_sr_q  <= {MAKER_CODE, MEM_TYPE_CODE, CAPACITY_CODE};
      end
      else if (cnt_q == FULL_BITS - 6'h1 && cmd_q == OP_MAKER_PAIR && awake)
      begin
        out_act_q <= 1'b1;
        if (sr_d[0])
          out_sr_q <= {DEVICE_CODE, MAKER_CODE, DEVICE_CODE};
        else
          out_sr_q <= {MAKER_CODE, DEVICE_CODE, MAKER_CODE};
      end
      else if (cnt_q == FULL_BITS - 6'h1 && cmd_q == OP_WAKE_SIG)
      begin
        out_act_q <= 1'b1;
        out_sr_q  <= {DEVICE_CODE, DEVICE_CODE, DEVICE_CODE};
      end
    end
    else if (clk_fall && out_act_q)
      out_sr_q <= {out_sr_q[22:0], out_sr_q[23]};
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in || !sel_low)
    begin
      miso_q <= 1'b0;
      oe_n_q <= 1'b1;
    end
    else if (clk_fall && out_act_q)
    begin
      miso_q <= out_sr_q[23];
      oe_n_q <= 1'b0;
    end
  end

  assign link.miso_d    = miso_q;
  assign link.miso_oe_n = oe_n_q;

  // ----------------------------------------------------------------
  // User-side status, all registered
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      write_busy_flag_out    <= 1'b0;
      write_permit_latch_out <= 1'b0;
      deep_sleep_out         <= 1'b0;
      blank_blocks_out       <= '1;
    end
    else
    begin
      write_busy_flag_out    <= busy_q;
      write_permit_latch_out <= permit_q;
      deep_sleep_out         <= sleep_q;
      blank_blocks_out       <= blank_q;
    end
  end

endmodule
`default_nettype wire

// ==== flash_host_end.sv ====
`timescale 1ns/10ps
`default_nettype none
module flash_host_end
  import flash_link_pkg::*;
#(
  parameter int unsigned HALF_CYCLES = flash_link_pkg::HOST_HALF_CYC
)
(
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  spi_link_if.host         link,
  input  wire logic [1:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [31:0] rdata_out
);
  import flash_link_pkg::*;

  typedef enum logic [2:0]
  {
    H_IDLE  = 3'b000,
    H_SETUP = 3'b001,
    H_LOW   = 3'b010,
    H_HIGH  = 3'b011,
    H_TAIL  = 3'b100,
    H_GAP   = 3'b101
  } host_state_e;

  // ----------------------------------------------------------------
  // Registers and link state
  // ----------------------------------------------------------------
  host_state_e state_q;
  logic [23:0] addr_q;
  logic [23:0] rx_q;
  logic [31:0] tx_q;
  logic [5:0]  bits_left_q;
  logic [7:0]  div_q;
  logic        tick;
  logic        start;
  logic [1:0]  miso_q;
  logic        sel_n_q;
  logic        sclk_q;
  logic        mosi_q;
  logic [1:0]  tx_bytes;
  logic [1:0]  rx_bytes;

  assign tick     = (div_q == 8'(HALF_CYCLES - 1));
  assign start    = wr_in && addr_in == REG_CTRL && state_q == H_IDLE;
  assign tx_bytes = wdata_in[CTRL_TX_LSB +: 2];
  assign rx_bytes = wdata_in[CTRL_RX_LSB +: 2];

  // Serial output from the device is another domain
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      miso_q <= 2'h0;
    else
      miso_q <= {miso_q[0], link.miso_line};
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      addr_q <= 24'h0;
    else if (wr_in && addr_in == REG_ADDR)
      addr_q <= wdata_in[23:0];
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in || state_q == H_IDLE)
      div_q <= 8'h0;
    else if (tick)
      div_q <= 8'h0;
    else
      div_q <= div_q + 8'h1;
  end

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  // Select rises only after the last clock falls, so every frame ends on a byte boundary
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      state_q     <= H_IDLE;
      sel_n_q     <= 1'b1;
      sclk_q      <= 1'b0;
      mosi_q      <= 1'b0;
      tx_q        <= 32'h0;
      rx_q        <= 24'h0;
      bits_left_q <= 6'h0;
    end
    else
    begin
      unique case (state_q)
        H_IDLE:
          if (start)
          begin
            sel_n_q     <= 1'b0;
            tx_q        <= {wdata_in[7:0], addr_q};
            bits_left_q <= OPCODE_BITS + {1'b0, tx_bytes, 3'h0} + {1'b0, rx_bytes, 3'h0};
            state_q     <= H_SETUP;
          end
        H_SETUP:
          if (tick)
          begin
            mosi_q  <= tx_q[31];
            tx_q    <= {tx_q[30:0], 1'b0};
            state_q <= H_LOW;
          end
        H_LOW:
          if (tick)
          begin
            sclk_q  <= 1'b1;
            rx_q    <= {rx_q[22:0], miso_q[1]};
            state_q <= H_HIGH;
          end
        H_HIGH:
          if (tick)
          begin
            sclk_q <= 1'b0;
            if (bits_left_q == 6'h1)
              state_q <= H_TAIL;
            else
            begin
              bits_left_q <= bits_left_q - 6'h1;
              mosi_q      <= tx_q[31];
              tx_q        <= {tx_q[30:0], 1'b0};
              state_q     <= H_LOW;
            end
          end
        H_TAIL:
          if (tick)
          begin
            sel_n_q <= 1'b1;
            state_q <= H_GAP;
          end
        H_GAP:
          if (tick)
            state_q <= H_IDLE;
        default:
          state_q <= H_IDLE;
      endcase
    end
  end

  assign link.sel_n          = sel_n_q;
  assign link.sclk           = sclk_q;
  assign link.serial_in_line = mosi_q;

  // ----------------------------------------------------------------
  // Read port, data one cycle after strobe
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      rdata_out <= 32'h0;
    else if (rd_in)
    begin
      unique case (addr_in)
        REG_CTRL:   rdata_out <= {24'h0, tx_q[31:24]};
        REG_ADDR:   rdata_out <= {8'h0, addr_q};
        REG_RXDATA: rdata_out <= {8'h0, rx_q};
        REG_STATUS: rdata_out <= {31'h0, state_q != H_IDLE};
      endcase
    end
  end

endmodule
`default_nettype wire

// ==== flash_link_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
module flash_link_assertions
#(
  parameter int unsigned BLOCK_ERASE_CYCLES = 50,
  parameter int unsigned ARRAY_ERASE_CYCLES = 80,
  parameter int unsigned SLEEP_CYCLES       = 10
)
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic sel_n,
  input wire logic sclk,
  input wire logic miso_oe_n,
  input wire logic write_busy_flag_out,
  input wire logic write_permit_latch_out,
  input wire logic deep_sleep_out
);
  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  // Pins reach the device through two flops, so figures carry a small margin
  int   busy_cnt_q;
  int   since_sel_q;
  logic sel_q;

  always_ff @(posedge clk_in)
  begin
    if (reset_in) busy_cnt_q <= 0;
    else if (write_busy_flag_out) busy_cnt_q <= busy_cnt_q + 1;
    else busy_cnt_q <= 0;
  end

  always_ff @(posedge clk_in)
  begin
    sel_q <= sel_n;
    if (reset_in || (sel_n && !sel_q)) since_sel_q <= 0;
    else if (since_sel_q < 100000) since_sel_q <= since_sel_q + 1;
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  sequence s_deselected;
    sel_n [*6];
  endsequence
  sequence s_erase_start;
    $rose(write_busy_flag_out);
  endsequence
  sequence s_erase_end;
    $fell(write_busy_flag_out);
  endsequence

  a_idle_hiz: assert property (s_deselected |-> miso_oe_n)
    else $error("serial output driven while deselected");
  a_sclk_still: assert property (sel_n |-> !sclk)
    else $error("link clock moves outside a frame");
  a_erase_on_rise: assert property (s_erase_start |-> sel_n && since_sel_q <= 8)
    else $error("erase started away from a select rise");
  a_erase_length: assert property (s_erase_end |->
    (busy_cnt_q + 2 >= BLOCK_ERASE_CYCLES && busy_cnt_q <= BLOCK_ERASE_CYCLES + 2) ||
    (busy_cnt_q + 2 >= ARRAY_ERASE_CYCLES && busy_cnt_q <= ARRAY_ERASE_CYCLES + 2))
    else $error("erase busy time wrong");
  a_permit_cleared: assert property (s_erase_end |-> !write_permit_latch_out)
    else $error("write permit still set at erase end");
  a_sleep_entry: assert property ($rose(deep_sleep_out) |->
    !write_busy_flag_out && since_sel_q >= SLEEP_CYCLES)
    else $error("deep sleep entered too early or while busy");
  a_sleep_no_erase: assert property (deep_sleep_out |-> !$rose(write_busy_flag_out))
    else $error("erase started in deep sleep");
  a_read_phase: assert property ($fell(miso_oe_n) |-> !sel_n && !sclk && !write_busy_flag_out)
    else $error("serial output enabled out of data phase");
  a_power_up: assert property ($fell(reset_in) |->
    !deep_sleep_out && !write_busy_flag_out && !write_permit_latch_out)
    else $error("device not in standby after reset");
endmodule
`default_nettype wire

// ==== flash_link_pkg.sv ====
`default_nettype none
package flash_link_pkg;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_WRITE_UNLOCK  = 8'h06;
  localparam logic [7:0] OP_BLOCK_ERASE   = 8'hD8;
  localparam logic [7:0] OP_ARRAY_ERASE   = 8'hC7;
  localparam logic [7:0] OP_DEEP_SLEEP    = 8'hB9;
  localparam logic [7:0] OP_WAKE_SIG      = 8'hAB;
  localparam logic [7:0] OP_IDENT_TRIPLET = 8'h9F;
  localparam logic [7:0] OP_MAKER_PAIR    = 8'h90;

  // ----------------------------------------------------------------
  // Identity bytes, values arbitrary
  // ----------------------------------------------------------------
  localparam logic [7:0] MAKER_CODE    = 8'h5A;
  localparam logic [7:0] MEM_TYPE_CODE = 8'h42;
  localparam logic [7:0] CAPACITY_CODE = 8'h10;
  localparam logic [7:0] DEVICE_CODE   = 8'h21;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int unsigned NUM_BLOCKS   = 16;
  localparam logic [5:0]  OPCODE_BITS  = 6'h08;
  localparam logic [5:0]  FULL_BITS    = 6'h20;
  localparam int unsigned BLOCK_LSB    = 16;
  localparam int unsigned BLOCK_W      = 4;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS    = 10;
  localparam int unsigned BLOCK_ERASE_US   = 1000;
  localparam int unsigned ARRAY_ERASE_US   = 4000;
  localparam int unsigned SLEEP_ENTRY_NS   = 3000;
  localparam int unsigned BLOCK_ERASE_CYC  = (BLOCK_ERASE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ARRAY_ERASE_CYC  = (ARRAY_ERASE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SLEEP_ENTRY_CYC  = (SLEEP_ENTRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HOST_HALF_CYC    = 8;

  // ----------------------------------------------------------------
  // Host register map
  // ----------------------------------------------------------------
  localparam logic [1:0] REG_CTRL   = 2'h0;
  localparam logic [1:0] REG_ADDR   = 2'h1;
  localparam logic [1:0] REG_RXDATA = 2'h2;
  localparam logic [1:0] REG_STATUS = 2'h3;
  localparam int unsigned CTRL_TX_LSB = 8;
  localparam int unsigned CTRL_RX_LSB = 10;

endpackage
`default_nettype wire

// ==== spi_link_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface spi_link_if;
  logic sel_n;
  logic sclk;
  logic serial_in_line;
  logic miso_d;
  logic miso_oe_n;
  wire  miso_line;

  // Device drives serial output only while enable is low
  // Released line rests at its pull-up level, so the host never samples a float
  assign miso_line = miso_oe_n ? 1'b1 : miso_d;

  modport device (input sel_n, input sclk, input serial_in_line, output miso_d, output miso_oe_n);
  modport host (output sel_n, output sclk, output serial_in_line, input miso_line);
endinterface
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import flash_link_pkg::*;
  typedef struct {logic [7:0] op; logic [1:0] na; logic [1:0] nr; logic [23:0] adr; logic [23:0] exp;} row_s;
  localparam int BLK = 1500;
  localparam int ARR = 2500;
  localparam int SLP = 10;
  logic            clk_in = 0;
  logic            reset_in = 1;
  logic [1:0]      addr_in = 0;
  logic [31:0]     wdata_in = 0;
  logic            wr_in = 0;
  logic            rd_in = 0;
  logic [31:0]     rdata_out;
  logic [15:0]     dirty = 0;
  logic [15:0]     blank;
  logic [2:0]      prot = 0;
  logic            busy;
  logic            permit;
  logic            sleep;
  logic [31:0]     rx;
  logic [23:0]     mask;
  int              error_cnt = 0;
  int              tests_run = 0;
  row_s            rows[4] = '{
    '{OP_IDENT_TRIPLET, 2'd0, 2'd3, 24'h000000, {MAKER_CODE, MEM_TYPE_CODE, CAPACITY_CODE}},
    '{OP_IDENT_TRIPLET, 2'd0, 2'd1, 24'h000000, {16'h0000, MAKER_CODE}},
    '{OP_MAKER_PAIR,    2'd3, 2'd2, 24'h000000, {8'h00, MAKER_CODE, DEVICE_CODE}},
    '{OP_MAKER_PAIR,    2'd3, 2'd2, 24'h000001, {8'h00, DEVICE_CODE, MAKER_CODE}}};

  always #5 clk_in = ~clk_in;

  spi_link_if link();
  flash_dev_end #(.BLOCK_ERASE_CYCLES(BLK), .ARRAY_ERASE_CYCLES(ARR), .SLEEP_CYCLES(SLP)) flash_dev_end_i (
    .clk_in(clk_in), .reset_in(reset_in), .link(link), .dirty_blocks_in(dirty), .protect_level_bits_in(prot),
    .write_busy_flag_out(busy), .write_permit_latch_out(permit), .deep_sleep_out(sleep), .blank_blocks_out(blank));
  flash_host_end flash_host_end_i (.clk_in(clk_in), .reset_in(reset_in), .link(link), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out));
  flash_link_assertions #(.BLOCK_ERASE_CYCLES(BLK), .ARRAY_ERASE_CYCLES(ARR), .SLEEP_CYCLES(SLP))
    flash_link_assertions_i (.clk_in(clk_in), .reset_in(reset_in), .sel_n(link.sel_n), .sclk(link.sclk),
    .miso_oe_n(link.miso_oe_n), .write_busy_flag_out(busy), .write_permit_latch_out(permit), .deep_sleep_out(sleep));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic hang(input string what);
    error_cnt++;
    $display("FAIL %0t no end of %s", $time, what);
    complete_run();
  endtask

  task automatic wr(input logic [1:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, output logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask

  // Runs one whole link frame and returns what the host shifted in
  task automatic frame(input logic [7:0] op, input logic [1:0] na, input logic [1:0] nr,
                       input logic [23:0] a, output logic [31:0] d);
    logic [31:0] st;
    int          n;
    n = 0;
    wr(REG_ADDR, {8'h00, a});
    wr(REG_CTRL, {20'h00000, nr, na, op});
    st = 32'h00000001;
    while (st[0] !== 1'b0)
    begin
      if (n++ > 2000) hang("link frame");
      rd(REG_STATUS, st);
    end
    rd(REG_RXDATA, d);
  endtask

  task automatic cmd(input logic [7:0] op, input logic [1:0] na, input logic [23:0] a);
    logic [31:0] junk;
    frame(op, na, 2'd0, a, junk);
  endtask

  task automatic mark(input logic [15:0] m);
    @(posedge clk_in);
    dirty <= m;
    @(posedge clk_in);
    dirty <= 16'h0000;
    @(negedge clk_in);
  endtask

  task automatic wait_erase;
    int n;
    n = 0;
    while (busy !== 1'b0)
    begin
      if (n++ > 4000) hang("erase");
      @(negedge clk_in);
    end
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge clk_in);
    reset_in <= 1'b0;
    @(negedge clk_in);
    check({13'h0000, sleep, busy, permit}, 32'h00000000);
    check({16'h0000, blank}, 32'h0000FFFF);
    for (int i = 0; i < 4; i++)
    begin
      frame(rows[i].op, rows[i].na, rows[i].nr, rows[i].adr, rx);
      mask = (24'h000001 << (8 * rows[i].nr)) - 24'h000001;
      check({8'h00, rx[23:0] & mask}, {8'h00, rows[i].exp & mask});
    end
    rd(REG_ADDR, rx);
    check(rx, 32'h00000001);
    check({31'h00000000, sleep}, 32'h00000000);
    done("ident reads");
    // Block erase: short frame refused, top nibble ignored, busy refuses others
    mark(16'h8008);
    cmd(OP_ARRAY_ERASE, 2'd0, 24'h000000);
    check({31'h00000000, busy}, 32'h00000000);
    cmd(OP_WRITE_UNLOCK, 2'd0, 24'h000000);
    check({31'h00000000, permit}, 32'h00000001);
    cmd(OP_BLOCK_ERASE, 2'd2, 24'hF30000);
    check({15'h0000, busy, blank}, 32'h00007FF7);
    cmd(OP_WRITE_UNLOCK, 2'd0, 24'h000000);
    cmd(OP_BLOCK_ERASE, 2'd3, 24'hF30000);
    check({30'h00000000, busy, permit}, 32'h00000002);
    // An ignored read leaves the line released, so only pull-up ones come back
    frame(OP_IDENT_TRIPLET, 2'd0, 2'd3, 24'h000000, rx);
    check(rx, 32'h00FFFFFF);
    cmd(OP_DEEP_SLEEP, 2'd0, 24'h000000);
    repeat (SLP + 4) @(negedge clk_in);
    check({30'h00000000, busy, sleep}, 32'h00000002);
    wait_erase();
    check({16'h0000, blank}, 32'h00007FFF);
    done("block erase");
    // Protection and array erase
    @(posedge clk_in);
    prot <= 3'd1;
    cmd(OP_WRITE_UNLOCK, 2'd0, 24'h000000);
    cmd(OP_BLOCK_ERASE, 2'd3, 24'h0F0000);
    check({15'h0000, busy, blank}, 32'h00007FFF);
    cmd(OP_ARRAY_ERASE, 2'd0, 24'h000000);
    check({31'h00000000, busy}, 32'h00000000);
    @(posedge clk_in);
    prot <= 3'd0;
    cmd(OP_WRITE_UNLOCK, 2'd0, 24'h000000);
    cmd(OP_ARRAY_ERASE, 2'd1, 24'h000000);
    check({31'h00000000, busy}, 32'h00000000);
    cmd(OP_WRITE_UNLOCK, 2'd0, 24'h000000);
    cmd(OP_ARRAY_ERASE, 2'd0, 24'h000000);
    check({31'h00000000, busy}, 32'h00000001);
    wait_erase();
    check({16'h0000, blank}, 32'h0000FFFF);
    done("array erase");
    // Deep sleep entry, refusal inside it, wake
    cmd(OP_DEEP_SLEEP, 2'd1, 24'h000000);
    repeat (SLP + 4) @(negedge clk_in);
    check({31'h00000000, sleep}, 32'h00000000);
    cmd(OP_DEEP_SLEEP, 2'd0, 24'h000000);
    repeat (SLP + 4) @(negedge clk_in);
    check({31'h00000000, sleep}, 32'h00000001);
    mark(16'h0001);
    cmd(OP_WRITE_UNLOCK, 2'd0, 24'h000000);
    cmd(OP_BLOCK_ERASE, 2'd3, 24'h000000);
    check({14'h0000, busy, permit, blank}, 32'h0000FFFE);
    frame(OP_WAKE_SIG, 2'd3, 2'd1, 24'h000000, rx);
    check({24'h000000, rx[7:0]}, {24'h000000, DEVICE_CODE});
    repeat (4) @(negedge clk_in);
    check({31'h00000000, sleep}, 32'h00000000);
    done("deep sleep");
    // Reset while latched and asleep
    cmd(OP_WRITE_UNLOCK, 2'd0, 24'h000000);
    cmd(OP_DEEP_SLEEP, 2'd0, 24'h000000);
    repeat (SLP + 4) @(negedge clk_in);
    check({13'h0000, sleep, busy, permit}, 32'h00000005);
    @(posedge clk_in);
    reset_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    @(negedge clk_in);
    check({13'h0000, sleep, busy, permit}, 32'h00000000);
    done("reset");
    complete_run();
  end
endmodule
`default_nettype wire
